// >>> inc/dldt_params.svh
// Notes on behaviour
// R1 - two skip points; both zero disables frequency skipping entirely.
// R2 - command inside a skip band runs at the nearer band edge.
// R3 - skip-during-ramp select; when set, ramping frequency jumps the band.
// R4 - level detector sets above its value, clears below value minus hysteresis.
// R5 - hysteresis is a percentage, 0 to 100, of the detector's own value.
// R6 - reached flag while running frequency within band of target.
// R7 - two match detectors: frequency within plus/minus amplitude of value.
// R8 - zero-current flag after current at or below level beyond delay.
// R9 - current in percent of rated, to 300; zero delay 0.01 s to 600 s.
// R10 - over-limit threshold zero disables detection; default 200 percent.
// R11 - over-limit flag after current at or above threshold beyond delay.
// R12 - two current match detectors: current within plus/minus amplitude.
// R13 - run minutes since start counted; flag when reaching programmed value.
// R14 - power-on hours counter reaching threshold asserts flag.
// R15 - running hours counter reaching threshold asserts flag.
// R16 - timed run: start timing at start, stop drive and flag at limit.
// R17 - timed-run count restarts at each start; remaining time is monitored.
// R18 - duration source: parameter, or analog input one, two, three scaled.
// R19 - module temperature flag when heatsink reaches threshold.
// R20 - comparisons on a sampling tick; delays count consecutive ticks. The skip band, the time flags and the qualifier lapse compare on every clock.
`ifndef DLDT_PARAMS_SVH
`define DLDT_PARAMS_SVH

// ************************************************************
// sampling and time bases
// ************************************************************
`define DLDT_CLK_HZ         100000000
`define DLDT_TICK_US        1000
`define DLDT_TICK_CYC       ((`DLDT_CLK_HZ / 1000000) * `DLDT_TICK_US)
`define DLDT_TICKS_PER_10MS 10
`define DLDT_TICKS_PER_6S   6000
`define DLDT_TENTHS_PER_HR  600
`define DLDT_FULL_PERMILLE  1000
`define DLDT_ANALOG_FULL    16'hFFFF

// ************************************************************
// reset values and timed-run source codes
// ************************************************************
`define DLDT_RST_FLAG       1'b0
`define DLDT_SRC_PARAM      2'h0
`define DLDT_SRC_AN1        2'h1
`define DLDT_SRC_AN2        2'h2
`define DLDT_SRC_AN3        2'h3

`endif

// >>> inc/dldt_pkg.sv
package dldt_pkg;
    typedef enum logic [1:0]
    {
        DLDT_IDLE    = 2'b00,
        DLDT_TIMING  = 2'b01,
        DLDT_EXPIRED = 2'b11
    } dldt_trun_t;
endpackage

// >>> rtl/dldt_qual.sv
`timescale 1ns/1ps
module dldt_qual
#(
    parameter int CW = 20
)
(
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    // condition and qualification
    input  wire logic          tick_in,
    input  wire logic          cond_in,
    input  wire logic [CW-1:0] delay_in,
    // qualified result
    output logic               flag_out
);
    logic [CW-1:0] cnt;
    wire  cnt_done = (cnt > delay_in);

    // consecutive qualifying ticks; any lapse restarts the count
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            cnt <= '0;
        else if (!cond_in)
            cnt <= '0; // [R20]
        else if (tick_in && !cnt_done)
            cnt <= cnt + CW'(1);
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            flag_out <= 1'b0;
        else
            flag_out <= cond_in && cnt_done; // [R8] [R11]
    end

    lapse_clears_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !cond_in |=> !flag_out) // [R20]
        else $error("qualified flag held after condition lapsed");
endmodule

// >>> rtl/dldt_top.sv
`timescale 1ns/1ps
`include "dldt_params.svh"
module dldt_top
#(
    parameter int FW        = 16,
    parameter int TICK_CYC  = `DLDT_TICK_CYC,
    parameter int TPM       = `DLDT_TICKS_PER_6S,
    parameter int DW        = 20
)
(
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    // drive state; frequencies in 0.01 Hz
    input  wire logic          running_in,
    input  wire logic          ramping_in,
    input  wire logic [FW-1:0] cmd_freq_in,
    input  wire logic [FW-1:0] run_freq_in,
    input  wire logic [FW-1:0] target_freq_in,
    input  wire logic [FW-1:0] max_freq_in,
    // current in 0.1 % of rated, temperature in degrees
    input  wire logic [11:0]   current_in,
    input  wire logic [7:0]    heatsink_temp_in,
    input  wire logic [15:0]   analog_input_one_in,
    input  wire logic [15:0]   analog_input_two_in,
    input  wire logic [15:0]   analog_input_three_in,
    // skip band settings
    input  wire logic [FW-1:0] skip_point_one_in,
    input  wire logic [FW-1:0] skip_point_two_in,
    input  wire logic [FW-1:0] skip_width_in,
    input  wire logic          skip_during_ramp_select_in,
    // level detectors; hysteresis in 0.1 %
    input  wire logic [FW-1:0] freq_level_detector_one_in,
    input  wire logic [9:0]    level_hyst_one_in,
    input  wire logic [FW-1:0] freq_level_detector_two_in,
    input  wire logic [9:0]    level_hyst_two_in,
    // frequency reached and match detectors; amplitudes 0.1 % of max
    input  wire logic [9:0]    reach_band_in,
    input  wire logic [FW-1:0] freq_match_one_in,
    input  wire logic [9:0]    freq_match_amp_one_in,
    input  wire logic [FW-1:0] freq_match_two_in,
    input  wire logic [9:0]    freq_match_amp_two_in,
    // current detectors; delays in ticks of 10 ms
    input  wire logic [11:0]   zero_level_in,
    input  wire logic [DW-1:0] zero_delay_in,
    input  wire logic [11:0]   over_level_in,
    input  wire logic [DW-1:0] over_delay_in,
    input  wire logic [11:0]   cur_match_one_in,
    input  wire logic [11:0]   cur_match_amp_one_in,
    input  wire logic [11:0]   cur_match_two_in,
    input  wire logic [11:0]   cur_match_amp_two_in,
    // time thresholds; minutes in 0.1 min
    input  wire logic [15:0]   run_minutes_target_in,
    input  wire logic [15:0]   powered_hours_target_in,
    input  wire logic [15:0]   running_hours_target_in,
    input  wire logic          timed_run_enable_in,
    input  wire logic [1:0]    timed_run_source_in,
    input  wire logic [15:0]   timed_run_minutes_in,
    input  wire logic [7:0]    temp_threshold_in,
    // effective frequency and flags
    output logic [FW-1:0]      eff_freq_out,
    output logic               level_one_out,
    output logic               level_two_out,
    output logic               freq_reached_out,
    output logic               freq_match_one_out,
    output logic               freq_match_two_out,
    output logic               zero_current_out,
    output logic               over_current_out,
    output logic               cur_match_one_out,
    output logic               cur_match_two_out,
    output logic               run_time_reached_out,
    output logic               powered_time_reached_out,
    output logic               running_time_reached_out,
    output logic               timed_run_done_out,
    output logic               timed_run_stop_out,
    output logic               temp_reached_out,
    // counters and monitor
    output logic [15:0]        accumulated_powered_hours_out,
    output logic [15:0]        accumulated_running_hours_out,
    output logic [15:0]        remaining_timer_monitor_out
);
    // ************************************************************
    // sampling tick and time bases
    // ************************************************************
    logic [31:0] tick_div;
    logic        tick;
    logic [3:0]  ms10_div;
    logic        tick10;
    logic [15:0] min_div;
    logic        min_tenth;
    logic [15:0] pw_div;
    logic [15:0] rn_div;
    logic        run_d;
    wire         start_pulse = running_in && !run_d;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            tick_div <= '0;
        else if (tick_div == 32'(TICK_CYC - 1))
            tick_div <= '0;
        else
            tick_div <= tick_div + 32'h1;
    end
    assign tick = (tick_div == 32'(TICK_CYC - 1)); // [R20]

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            ms10_div <= '0;
        else if (tick)
            ms10_div <= (ms10_div == 4'(`DLDT_TICKS_PER_10MS - 1))
                        ? 4'h0 : ms10_div + 4'h1;
    end
    assign tick10 = tick && (ms10_div == 4'(`DLDT_TICKS_PER_10MS - 1));

    // tenth-minute base restarts at each start so run time counts from it
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in || start_pulse)
            min_div <= '0;
        else if (tick)
            min_div <= (min_div == 16'(TPM - 1)) ? 16'h0 : min_div + 16'h1;
    end
    assign min_tenth = tick && running_in && (min_div == 16'(TPM - 1));

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            run_d <= 1'b0;
        else
            run_d <= running_in;
    end

    // ************************************************************
    // frequency skipping
    // ************************************************************
    wire [FW:0] half_w   = {1'b0, skip_width_in} >> 1;
    wire        skip_on  = (skip_point_one_in != '0)
                        || (skip_point_two_in != '0); // [R1]
    wire        skip_act = skip_on
                        && (!ramping_in || skip_during_ramp_select_in); // [R3]
    wire [FW:0] lo1 = ({1'b0, skip_point_one_in} > half_w)
                      ? {1'b0, skip_point_one_in} - half_w : '0;
    wire [FW:0] hi1 = {1'b0, skip_point_one_in} + half_w;
    wire [FW:0] lo2 = ({1'b0, skip_point_two_in} > half_w)
                      ? {1'b0, skip_point_two_in} - half_w : '0;
    wire [FW:0] hi2 = {1'b0, skip_point_two_in} + half_w;
    wire [FW:0] cmd = {1'b0, cmd_freq_in};
    wire in1 = (skip_point_one_in != '0) && cmd > lo1 && cmd < hi1;
    wire in2 = (skip_point_two_in != '0) && cmd > lo2 && cmd < hi2;
    wire [FW:0] edge1 = (cmd - lo1 <= hi1 - cmd) ? lo1 : hi1;
    wire [FW:0] edge2 = (cmd - lo2 <= hi2 - cmd) ? lo2 : hi2;
    wire [FW:0] skip_sel = !skip_act ? cmd : in1 ? edge1 : in2 ? edge2 : cmd;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            eff_freq_out <= '0;
        else
            eff_freq_out <= FW'(skip_sel); // [R2]
    end

    // ************************************************************
    // frequency detectors
    // ************************************************************
    wire [FW+9:0] hyst1 = (FW+10)'(freq_level_detector_one_in * level_hyst_one_in
                          / `DLDT_FULL_PERMILLE); // [R5]
    wire [FW+9:0] hyst2 = (FW+10)'(freq_level_detector_two_in * level_hyst_two_in
                          / `DLDT_FULL_PERMILLE); // [R5]
    wire [FW+9:0] rf   = (FW+10)'(run_freq_in);
    wire set1 = rf > (FW+10)'(freq_level_detector_one_in);
    wire set2 = rf > (FW+10)'(freq_level_detector_two_in);
    wire clr1 = rf + hyst1 < (FW+10)'(freq_level_detector_one_in);
    wire clr2 = rf + hyst2 < (FW+10)'(freq_level_detector_two_in);

    wire [FW+9:0] band_r = (FW+10)'(max_freq_in * reach_band_in
                           / `DLDT_FULL_PERMILLE);
    wire [FW+9:0] band_1 = (FW+10)'(max_freq_in * freq_match_amp_one_in
                           / `DLDT_FULL_PERMILLE);
    wire [FW+9:0] band_2 = (FW+10)'(max_freq_in * freq_match_amp_two_in
                           / `DLDT_FULL_PERMILLE);
    wire [FW+9:0] tg = (FW+10)'(target_freq_in);
    wire [FW+9:0] m1 = (FW+10)'(freq_match_one_in);
    wire [FW+9:0] m2 = (FW+10)'(freq_match_two_in);
    wire reach_c = rf + band_r >= tg && rf <= tg + band_r;
    wire fm1_c   = rf + band_1 >= m1 && rf <= m1 + band_1;
    wire fm2_c   = rf + band_2 >= m2 && rf <= m2 + band_2;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            level_one_out      <= `DLDT_RST_FLAG;
            level_two_out      <= `DLDT_RST_FLAG;
            freq_reached_out   <= `DLDT_RST_FLAG;
            freq_match_one_out <= `DLDT_RST_FLAG;
            freq_match_two_out <= `DLDT_RST_FLAG;
        end
        else if (tick)
        begin
            level_one_out      <= set1 | (level_one_out & !clr1); // [R4]
            level_two_out      <= set2 | (level_two_out & !clr2); // [R4]
            freq_reached_out   <= reach_c; // [R6]
            freq_match_one_out <= fm1_c; // [R7]
            freq_match_two_out <= fm2_c; // [R7]
        end
    end

    // ************************************************************
    // current detectors
    // ************************************************************
    wire [12:0] cur = {1'b0, current_in};
    wire zero_cond = current_in <= zero_level_in; // [R9]
    wire over_cond = (over_level_in != 12'h0)
                  && current_in >= over_level_in; // [R10]
    wire cm1_c = cur + {1'b0, cur_match_amp_one_in} >= {1'b0, cur_match_one_in}
              && cur <= {1'b0, cur_match_one_in} + {1'b0, cur_match_amp_one_in};
    wire cm2_c = cur + {1'b0, cur_match_amp_two_in} >= {1'b0, cur_match_two_in}
              && cur <= {1'b0, cur_match_two_in} + {1'b0, cur_match_amp_two_in};

    dldt_qual #(.CW(DW)) u_zero
    (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .tick_in  (tick10),
        .cond_in  (zero_cond),
        .delay_in (zero_delay_in),
        .flag_out (zero_current_out)
    ); // [R8]

    dldt_qual #(.CW(DW)) u_over
    (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .tick_in  (tick10),
        .cond_in  (over_cond),
        .delay_in (over_delay_in),
        .flag_out (over_current_out)
    ); // [R11]

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            cur_match_one_out <= `DLDT_RST_FLAG;
            cur_match_two_out <= `DLDT_RST_FLAG;
            temp_reached_out  <= `DLDT_RST_FLAG;
        end
        else if (tick)
        begin
            cur_match_one_out <= cm1_c; // [R12]
            cur_match_two_out <= cm2_c; // [R12]
            temp_reached_out  <= heatsink_temp_in >= temp_threshold_in; // [R19]
        end
    end

    // ************************************************************
    // run time and accumulated hours
    // ************************************************************
    logic [15:0] run_tenths;
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in || start_pulse)
            run_tenths <= '0; // [R13]
        else if (min_tenth && run_tenths != 16'hFFFF)
            run_tenths <= run_tenths + 16'h1;
    end

    // hour bases tick per tenth-minute; saturate rather than wrap
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pw_div <= '0;
            rn_div <= '0;
            accumulated_powered_hours_out <= '0;
            accumulated_running_hours_out <= '0;
        end
        else if (tick && min_div == 16'(TPM - 1))
        begin
            if (pw_div == 16'(`DLDT_TENTHS_PER_HR - 1))
            begin
                pw_div <= '0;
                if (accumulated_powered_hours_out != 16'hFFFF)
                    accumulated_powered_hours_out <=
                        accumulated_powered_hours_out + 16'h1;
            end
            else
                pw_div <= pw_div + 16'h1;
            if (running_in && rn_div == 16'(`DLDT_TENTHS_PER_HR - 1))
            begin
                rn_div <= '0;
                if (accumulated_running_hours_out != 16'hFFFF)
                    accumulated_running_hours_out <=
                        accumulated_running_hours_out + 16'h1;
            end
            else if (running_in)
                rn_div <= rn_div + 16'h1;
        end
    end

    assign run_time_reached_out = running_in && run_minutes_target_in != 16'h0
                               && run_tenths >= run_minutes_target_in; // [R13]
    assign powered_time_reached_out = powered_hours_target_in != 16'h0
        && accumulated_powered_hours_out >= powered_hours_target_in; // [R14]
    assign running_time_reached_out = running_hours_target_in != 16'h0
        && accumulated_running_hours_out >= running_hours_target_in; // [R15]

    // ************************************************************
    // timed run
    // ************************************************************
    wire [15:0] an_sel = (timed_run_source_in == `DLDT_SRC_AN1)
                         ? analog_input_one_in
                       : (timed_run_source_in == `DLDT_SRC_AN2)
                         ? analog_input_two_in : analog_input_three_in;
    wire [31:0] an_scaled = (32'(an_sel) * 32'(timed_run_minutes_in))
                            / 32'(`DLDT_ANALOG_FULL);
    wire [15:0] trun_limit = (timed_run_source_in == `DLDT_SRC_PARAM)
                             ? timed_run_minutes_in
                             : an_scaled[15:0]; // [R18]
    dldt_pkg::dldt_trun_t trun_st;
    dldt_pkg::dldt_trun_t next_trun_st;
    wire trun_hit = run_tenths >= trun_limit;

    always_comb
    begin
        next_trun_st = trun_st;
        unique case (trun_st)
            dldt_pkg::DLDT_IDLE:
                if (timed_run_enable_in && start_pulse)
                    next_trun_st = dldt_pkg::DLDT_TIMING; // [R16]
            dldt_pkg::DLDT_TIMING:
                if (!timed_run_enable_in || !running_in)
                    next_trun_st = dldt_pkg::DLDT_IDLE;
                else if (trun_hit)
                    next_trun_st = dldt_pkg::DLDT_EXPIRED; // [R16]
            dldt_pkg::DLDT_EXPIRED:
                if (start_pulse && timed_run_enable_in)
                    next_trun_st = dldt_pkg::DLDT_TIMING; // [R17]
                else if (!timed_run_enable_in)
                    next_trun_st = dldt_pkg::DLDT_IDLE;
            default:
                next_trun_st = dldt_pkg::DLDT_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            trun_st <= dldt_pkg::DLDT_IDLE;
        else
            trun_st <= next_trun_st;
    end

    // stop and flag rise together on the same expiry
    assign timed_run_done_out = (trun_st == dldt_pkg::DLDT_EXPIRED); // [R16]
    assign timed_run_stop_out = (trun_st == dldt_pkg::DLDT_EXPIRED); // [R16]

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            remaining_timer_monitor_out <= '0;
        else if (trun_st == dldt_pkg::DLDT_TIMING && !trun_hit)
            remaining_timer_monitor_out <= trun_limit - run_tenths; // [R17]
        else if (trun_st == dldt_pkg::DLDT_IDLE)
            remaining_timer_monitor_out <= trun_limit;
        else
            remaining_timer_monitor_out <= '0;
    end

    // ************************************************************
    // checks
    // ************************************************************
    skip_off_pass_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !skip_on |=> eff_freq_out == $past(cmd_freq_in)) // [R1]
        else $error("frequency altered with skipping disabled");
    skip_edge_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (skip_act && in1) |=> eff_freq_out == FW'($past(edge1))) // [R2]
        else $error("command inside band not moved to nearer edge");
    ramp_bypass_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (ramping_in && !skip_during_ramp_select_in)
        |=> eff_freq_out == $past(cmd_freq_in)) // [R3]
        else $error("band applied during ramp while disabled");
    level_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (tick && set1) |=> level_one_out) // [R4]
        else $error("level flag missed above detection value");
    level_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (tick && level_one_out && !clr1) |=> level_one_out) // [R5]
        else $error("level flag dropped inside hysteresis");
    reach_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tick |=> freq_reached_out == $past(reach_c)) // [R6]
        else $error("reached flag wrong");
    fmatch_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tick |=> freq_match_two_out == $past(fm2_c)) // [R7]
        else $error("frequency match flag wrong");
    over_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (over_level_in == 12'h0) [*2] |-> !over_current_out) // [R10]
        else $error("over-limit flagged while disabled");
    cmatch_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        tick |=> cur_match_one_out == $past(cm1_c)) // [R12]
        else $error("current match flag wrong");
    run_restart_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        start_pulse |=> run_tenths == 16'h0) // [R13]
        else $error("run time not restarted at start");
    trun_stop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (trun_st == dldt_pkg::DLDT_TIMING && running_in
         && timed_run_enable_in && trun_hit) |=> timed_run_stop_out) // [R16]
        else $error("timed run did not stop at limit");

    run_cover_c:   cover property (@(posedge clk_in) start_pulse);
    expire_cover_c: cover property (@(posedge clk_in) timed_run_stop_out);
    skip_cover_c:  cover property (@(posedge clk_in) skip_act && in2);
    zero_cover_c:  cover property (@(posedge clk_in) zero_current_out);
endmodule

// >>> testbench/tb_dldt_top.sv
`timescale 1ns/1ps
module tb_dldt_top;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic clk_in = 0, rstn_in = 0, running_in = 0, ramping_in = 0;
    logic skip_during_ramp_select_in = 0, timed_run_enable_in = 0;
    logic [1:0] timed_run_source_in = '0;
    logic [7:0] heatsink_temp_in = '0, temp_threshold_in = '0;
    logic [9:0] level_hyst_one_in = '0, level_hyst_two_in = '0;
    logic [9:0] reach_band_in = '0, freq_match_amp_one_in = '0;
    logic [9:0] freq_match_amp_two_in = '0;
    logic [11:0] current_in = '0, zero_level_in = '0, over_level_in = '0;
    logic [11:0] cur_match_one_in = '0, cur_match_amp_one_in = '0;
    logic [11:0] cur_match_two_in = '0, cur_match_amp_two_in = '0;
    logic [15:0] cmd_freq_in = '0, run_freq_in = '0, target_freq_in = '0;
    logic [15:0] max_freq_in = '0, analog_input_one_in = '0;
    logic [15:0] analog_input_two_in = '0, analog_input_three_in = '0;
    logic [15:0] skip_point_one_in = '0, skip_point_two_in = '0;
    logic [15:0] skip_width_in = '0, freq_level_detector_one_in = '0;
    logic [15:0] freq_level_detector_two_in = '0, freq_match_one_in = '0;
    logic [15:0] freq_match_two_in = '0, run_minutes_target_in = '0;
    logic [15:0] powered_hours_target_in = '0, running_hours_target_in = '0;
    logic [15:0] timed_run_minutes_in = '0;
    logic [19:0] zero_delay_in = '0, over_delay_in = '0;
    logic [15:0] eff_freq_out, accumulated_powered_hours_out;
    logic [15:0] accumulated_running_hours_out, remaining_timer_monitor_out;
    logic level_one_out, level_two_out, freq_reached_out, freq_match_one_out;
    logic freq_match_two_out, zero_current_out, over_current_out;
    logic cur_match_one_out, cur_match_two_out, run_time_reached_out;
    logic powered_time_reached_out, running_time_reached_out;
    logic timed_run_done_out, timed_run_stop_out, temp_reached_out;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    // short tick and minute bases keep the run brief
    dldt_top #(.TICK_CYC(10), .TPM(4)) DUT (.*);

    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // tick flags settle within three sampling ticks of 10 cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            final_report();
        end
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        skip_point_one_in <= 16'h03E8;
        skip_width_in <= 16'h00C8;
        cmd_freq_in <= 16'h03B6;
        max_freq_in <= 16'h2710;
        target_freq_in <= 16'h1388;
        reach_band_in <= 10'h00A;
        run_freq_in <= 16'h1389;
        freq_level_detector_one_in <= 16'h1388;
        level_hyst_one_in <= 10'h032;
        zero_level_in <= 12'h032;
        zero_delay_in <= 20'h00001;
        current_in <= 12'h00A;
        freq_level_detector_two_in <= 16'h1770;
        freq_match_one_in <= 16'h1388;
        freq_match_amp_one_in <= 10'h001;
        freq_match_two_in <= 16'h1770;
        freq_match_amp_two_in <= 10'h00A;
        cur_match_one_in <= 12'h00C;
        cur_match_amp_one_in <= 12'h002;
        cur_match_two_in <= 12'h064;
        cur_match_amp_two_in <= 12'h00A;
        heatsink_temp_in <= 8'h50;
        temp_threshold_in <= 8'h4B;
        cyc(30);
        chk(eff_freq_out, 16'h0384);
        chk(level_one_out, 1'b1);
        chk(freq_reached_out, 1'b1);
        chk(over_current_out, 1'b0);
        chk(level_two_out, 1'b0);
        chk(freq_match_one_out, 1'b1);
        chk(freq_match_two_out, 1'b0);
        chk(cur_match_one_out, 1'b1);
        chk(cur_match_two_out, 1'b0);
        chk(temp_reached_out, 1'b1);
        @(posedge clk_in);
        cmd_freq_in <= 16'h0424;
        run_freq_in <= 16'h12C0;
        ramping_in <= 1'b1;
        skip_during_ramp_select_in <= 1'b1;
        cyc(30);
        chk(eff_freq_out, 16'h044C);
        chk(level_one_out, 1'b1);
        @(posedge clk_in);
        run_freq_in <= 16'h125C;
        skip_during_ramp_select_in <= 1'b0;
        cyc(30);
        chk(eff_freq_out, 16'h0424);
        chk(level_one_out, 1'b0);
        chk(zero_current_out, 1'b0);
        @(posedge clk_in);
        skip_point_one_in <= 16'h0000;
        ramping_in <= 1'b0;
        cyc(200);
        chk(zero_current_out, 1'b1);
        chk(eff_freq_out, 16'h0424);
        @(posedge clk_in);
        current_in <= 12'h0C8;
        over_level_in <= 12'h064;
        timed_run_enable_in <= 1'b1;
        timed_run_minutes_in <= 16'h0002;
        run_minutes_target_in <= 16'h0001;
        powered_hours_target_in <= 16'h0001;
        running_hours_target_in <= 16'h0001;
        running_in <= 1'b1;
        cyc(40);
        chk(over_current_out, 1'b1);
        chk(zero_current_out, 1'b0);
        chk(run_time_reached_out, 1'b1);
        chk(remaining_timer_monitor_out, 16'h0001);
        chk(powered_time_reached_out, 1'b0);
        chk(timed_run_stop_out, 1'b0);
        cyc(80);
        chk(timed_run_stop_out, 1'b1);
        chk(timed_run_done_out, 1'b1);
        @(posedge clk_in);
        running_in <= 1'b0;
        cyc(2);
        @(posedge clk_in);
        running_in <= 1'b1;
        timed_run_source_in <= 2'h1;
        analog_input_one_in <= 16'h8000;
        timed_run_minutes_in <= 16'h0064;
        cyc(5);
        chk(timed_run_stop_out, 1'b0);
        chk(remaining_timer_monitor_out, 16'h0032);
        // one hour of the shortened tenth-minute base is 600 of them
        cyc(24000);
        chk(accumulated_powered_hours_out, 16'h0001);
        chk(accumulated_running_hours_out, 16'h0001);
        chk(powered_time_reached_out, 1'b1);
        chk(running_time_reached_out, 1'b1);
        chk(timed_run_stop_out, 1'b1);
        final_report();
    end
endmodule
